// File: hw/uaez_ctrl.sv
// USB device addresses, endpoint FIFO routing and endpoint-zero mode registers
// How it works
// RULE1 - Two device-address registers A and B, seven address bits plus enable.
// RULE2 - Cleared config gives address A three endpoints and address B two.
// RULE3 - Reset zeroes both address registers, so neither address is active.
// RULE4 - Firmware loads each address with the nonzero value the host assigned.
// RULE5 - Traffic to an address is answered only while its enable bit is set.
// RULE6 - Status register bits 7 and 6 pick FIFO sizes and address count.
// RULE7 - Size bit clear: five 8-byte FIFOs from 0xD8 to 0xF8.
// RULE8 - Size bit set: 8-byte FIFOs at 0xA8/0xB0/0xB8, 32-byte at 0xC0/0xE0.
// RULE9 - Each engine byte written to a FIFO stalls the CPU three cycles.
// RULE10 - Endpoint zero is bidirectional; others carry one firmware-chosen direction.
// RULE11 - Mode registers clear on reset; two-address modes use control layout.
// RULE12 - Low four mode bits decide how the endpoint answers traffic.
// RULE13 - Engine sets the ACK flag when a transaction ends with ACK.
// RULE14 - Engine sets OUT or IN received flags; firmware clears them.
// RULE15 - Only the engine sets SETUP received; any CPU write clears it.
// RULE16 - SETUP flag held high from setup data start until ACK start.
// RULE17 - Firmware clears SETUP only after the hold and a register read.
// RULE18 - In five-endpoint modes register 0x42 is non-control endpoint three.
// RULE19 - Engine update of bits 6:0 locks CPU writes until a CPU read.
// RULE20 - Write lock applies to endpoint-zero mode registers only.
// RULE21 - Firmware reads back each endpoint-zero write to confirm it.
// RULE22 - CPU writes to endpoint-zero FIFO are blocked while SETUP is set.
// RULE23 - No ack-out/nak-in mode; a new setup may overwrite control-write data.
// RULE24 - Mode 0000 ignores all traffic and is the reset mode.
// RULE25 - Setup token on an enabled control endpoint forces mode 0001.
// RULE26 - Bus activity bit set by engine, cleared by writing zero.
// RULE27 - Token address matched against enabled addresses and routed per config.
`timescale 1ns/1ps
module uaez_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic i_cpu_ram_we,
  input wire logic [7:0] i_cpu_ram_addr,
  output logic o_cpu_ram_we,
  input wire logic i_tok_valid,
  input wire logic [1:0] i_tok_pid,
  input wire logic [6:0] i_tok_addr,
  input wire logic [3:0] i_tok_ep,
  input wire logic i_data_start,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_ack_start,
  input wire logic i_txn_end,
  input wire logic i_bus_event,
  input wire logic i_dp,
  input wire logic i_dm,
  output logic o_tok_hit,
  output logic o_tok_sel_b,
  output logic [2:0] o_tok_slot,
  output logic o_ep0_ignore,
  output logic [3:0] o_ep0_mode,
  output logic [2:0] o_force_ctl,
  output logic o_cpu_stall,
  output logic o_ram_we,
  output logic [7:0] o_ram_addr,
  output logic [7:0] o_ram_wdata
);
  logic [7:0] addr_a_q;
  logic [7:0] addr_b_q;
  logic [7:0] sc_q;
  logic [1:0] dp_sync_q;
  logic [1:0] dm_sync_q;
  logic [7:0] ep0_q [2];
  logic [7:0] ep0_d [2];
  logic [1:0] lock_q;
  logic [1:0] lock_d;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  logic [1:0] ctl_fmt;
  logic [1:0] tgt_now;
  logic [1:0] cur_tgt_q;
  logic cur_act_q;
  logic [1:0] cur_pid_q;
  logic [2:0] cur_slot_q;
  logic [5:0] off_q;
  logic map_hit;
  logic map_sel_b;
  logic [2:0] map_slot;
  logic [1:0] cfg;
  logic wr_a;
  logic wr_b;
  logic rd_a;
  logic rd_b;
  logic fifo_prot;
  logic fifo_take;
  uaez_fifo_if fifo ();

  assign cfg = {sc_q[uaez_pkg::CFG_SIZE_BIT], sc_q[uaez_pkg::CFG_MODE_BIT]}; // RULE6
  assign wr_a = i_io_wr && (i_io_addr == uaez_pkg::EP0_A_OFS);
  assign wr_b = i_io_wr && (i_io_addr == uaez_pkg::EP0_B_OFS);
  assign rd_a = i_io_rd && (i_io_addr == uaez_pkg::EP0_A_OFS);
  assign rd_b = i_io_rd && (i_io_addr == uaez_pkg::EP0_B_OFS);
  // Register 0x42 keeps the control layout only in two-address modes
  assign ctl_fmt = {!cfg[0], 1'b1}; // RULE11 RULE18

  uaez_ep_map u_map (
    .i_cfg(cfg),
    .i_addr_a(addr_a_q),
    .i_addr_b(addr_b_q),
    .i_tok_addr(i_tok_addr),
    .i_tok_ep(i_tok_ep),
    .o_hit(map_hit),
    .o_sel_b(map_sel_b),
    .o_slot(map_slot)
  );

  uaez_fifo_wr u_wr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .fifo(fifo.sink),
    .o_cpu_stall(o_cpu_stall),
    .o_ram_we(o_ram_we),
    .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata)
  );

  // Pin levels pass two flip-flops before use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_sync_q <= 2'h0;
      dm_sync_q <= 2'h0;
    end else begin
      dp_sync_q <= {dp_sync_q[0], i_dp};
      dm_sync_q <= {dm_sync_q[0], i_dm};
    end
  end

  // Device address registers, cleared by reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_a_q <= uaez_pkg::REG_RESET; // RULE3
      addr_b_q <= uaez_pkg::REG_RESET; // RULE3
    end else begin
      if (i_io_wr && i_io_addr == uaez_pkg::ADDR_A_OFS) begin
        addr_a_q <= i_io_wdata; // RULE1
      end
      if (i_io_wr && i_io_addr == uaez_pkg::ADDR_B_OFS) begin
        addr_b_q <= i_io_wdata; // RULE1
      end
    end
  end

  // Status and control: config, sticky activity, forced drive bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sc_q <= uaez_pkg::REG_RESET; // RULE2
    end else begin
      if (i_io_wr && i_io_addr == uaez_pkg::USB_SC_OFS) begin
        sc_q[7:6] <= i_io_wdata[7:6]; // RULE6
        sc_q[2:0] <= i_io_wdata[2:0];
        sc_q[uaez_pkg::ACT_BIT] <= sc_q[uaez_pkg::ACT_BIT] &&
                                   i_io_wdata[uaez_pkg::ACT_BIT]; // RULE26
      end
      if (i_bus_event) begin
        sc_q[uaez_pkg::ACT_BIT] <= 1'b1; // RULE26
      end
    end
  end
  assign o_force_ctl = sc_q[2:0];

  // Which endpoint-zero register a new token hits
  always_comb begin
    tgt_now[0] = i_tok_valid && map_hit && (map_slot == 3'h0);
    tgt_now[1] = i_tok_valid && map_hit && (map_slot == uaez_pkg::SLOT_B_OFS);
  end

  // Current transaction context
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_tgt_q <= 2'h0;
      cur_act_q <= 1'b0;
      cur_pid_q <= uaez_pkg::UAEZ_PID_NONE;
      cur_slot_q <= 3'h0;
    end else if (i_tok_valid) begin
      cur_tgt_q <= tgt_now;
      cur_pid_q <= i_tok_pid;
      cur_slot_q <= map_slot;
      // Disabled control endpoints take no data at all
      cur_act_q <= map_hit && !((tgt_now[0] && ep0_q[0][3:0] == uaez_pkg::MODE_DISABLE) || // RULE24
                               (tgt_now[1] && ep0_q[1][3:0] == uaez_pkg::MODE_DISABLE));
    end else if (i_txn_end) begin
      cur_tgt_q <= 2'h0;
      cur_act_q <= 1'b0;
      cur_pid_q <= uaez_pkg::UAEZ_PID_NONE;
    end
  end

  // Mode, flags, lock and setup hold of both endpoint-zero registers
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      ep0_d[r] = ep0_q[r];
      lock_d[r] = lock_q[r];
      hold_d[r] = hold_q[r];
      if ((r == 0) ? wr_a : wr_b) begin
        if (!ctl_fmt[r]) begin
          ep0_d[r] = i_io_wdata & uaez_pkg::NONCTL_WMASK; // RULE20
        end else begin
          ep0_d[r][uaez_pkg::SETUP_BIT] = 1'b0; // RULE15
          if (!lock_q[r]) begin
            ep0_d[r][6:0] = i_io_wdata[6:0]; // RULE19
          end
        end
      end
      if (((r == 0) ? rd_a : rd_b) && ctl_fmt[r]) begin
        lock_d[r] = 1'b0; // RULE19
      end
      // Engine updates follow, so a set wins over a CPU clear
      if (tgt_now[r] && ctl_fmt[r] && ep0_q[r][3:0] != uaez_pkg::MODE_DISABLE) begin // RULE24
        case (i_tok_pid)
          uaez_pkg::UAEZ_PID_OUT: ep0_d[r][uaez_pkg::OUT_BIT] = 1'b1; // RULE14
          uaez_pkg::UAEZ_PID_IN: ep0_d[r][uaez_pkg::IN_BIT] = 1'b1; // RULE14
          uaez_pkg::UAEZ_PID_SETUP: ep0_d[r][3:0] = uaez_pkg::MODE_NAK_INOUT; // RULE25
          default: ep0_d[r] = ep0_d[r];
        endcase
        lock_d[r] = 1'b1; // RULE19
      end
      if (i_data_start && cur_tgt_q[r] && cur_act_q && ctl_fmt[r] &&
          cur_pid_q == uaez_pkg::UAEZ_PID_SETUP) begin
        hold_d[r] = 1'b1; // RULE16
      end
      if (i_ack_start && cur_tgt_q[r]) begin
        hold_d[r] = 1'b0; // RULE16
        ep0_d[r][uaez_pkg::ACK_BIT] = 1'b1; // RULE13
        if (ctl_fmt[r]) begin
          lock_d[r] = 1'b1; // RULE19
        end
      end
      // Held setup flag overrides any CPU clear
      if (hold_d[r]) begin
        ep0_d[r][uaez_pkg::SETUP_BIT] = 1'b1; // RULE15 RULE16
      end
      // Non-control layout has neither lock nor hold
      if (!ctl_fmt[r]) begin
        lock_d[r] = 1'b0; // RULE20
        hold_d[r] = 1'b0;
      end
    end
  end

  // Endpoint-zero register state, cleared by reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ep0_q[0] <= uaez_pkg::REG_RESET; // RULE11 RULE24
      ep0_q[1] <= uaez_pkg::REG_RESET; // RULE11 RULE24
      lock_q <= 2'h0;
      hold_q <= 2'h0;
    end else begin
      ep0_q[0] <= ep0_d[0];
      ep0_q[1] <= ep0_d[1];
      lock_q <= lock_d;
      hold_q <= hold_d;
    end
  end

  // Received data bytes go to the routed FIFO; setup data lands in every mode except disable
  assign fifo_take = i_rx_valid && cur_act_q && cur_pid_q != uaez_pkg::UAEZ_PID_IN && // RULE10
                     (off_q < uaez_pkg::slot_size(cfg[1], cur_slot_q)) && !fifo.busy; // RULE23
  assign fifo.wr_req = fifo_take;
  assign fifo.wr_addr = uaez_pkg::slot_base(cfg[1], cur_slot_q) + {2'h0, off_q}; // RULE7 RULE8
  assign fifo.wr_data = i_rx_byte;

  // FIFO byte offset within the packet
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      off_q <= 6'h00;
    end else if (i_data_start) begin
      off_q <= 6'h00;
    end else if (fifo_take) begin
      off_q <= off_q + 6'h01;
    end
  end

  // CPU RAM writes blocked over endpoint-zero FIFO while SETUP is set
  assign fifo_prot = (ep0_q[0][uaez_pkg::SETUP_BIT] &&
                      uaez_pkg::in_fifo(cfg[1], 3'h0, i_cpu_ram_addr)) ||
                     (ctl_fmt[1] && ep0_q[1][uaez_pkg::SETUP_BIT] &&
                      uaez_pkg::in_fifo(cfg[1], uaez_pkg::SLOT_B_OFS, i_cpu_ram_addr));
  assign o_cpu_ram_we = i_cpu_ram_we && !fifo_prot; // RULE22

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd) begin
      case (i_io_addr)
        uaez_pkg::ADDR_A_OFS: o_io_rdata <= addr_a_q;
        uaez_pkg::ADDR_B_OFS: o_io_rdata <= addr_b_q;
        uaez_pkg::EP0_A_OFS: o_io_rdata <= ep0_q[0];
        uaez_pkg::EP0_B_OFS: o_io_rdata <= ep0_q[1];
        uaez_pkg::USB_SC_OFS: o_io_rdata <= {sc_q[7:6], dp_sync_q[1], dm_sync_q[1], sc_q[3:0]};
        default: o_io_rdata <= 8'h00;
      endcase
    end
  end

  // Routing and endpoint-zero response to the engine
  assign o_tok_hit = map_hit;
  assign o_tok_sel_b = map_sel_b;
  assign o_tok_slot = map_slot;
  assign o_ep0_mode = tgt_now[1] ? ep0_q[1][3:0] : ep0_q[0][3:0]; // RULE12
  assign o_ep0_ignore = (tgt_now[0] || tgt_now[1]) && o_ep0_mode == uaez_pkg::MODE_DISABLE; // RULE24

  a_hit_needs_enable: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    map_hit |-> (addr_a_q[uaez_pkg::ADDR_EN_BIT] || addr_b_q[uaez_pkg::ADDR_EN_BIT]))
    else $error("token matched a disabled address");
  a_setup_held_high: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE16
    hold_q[0] |-> ep0_q[0][uaez_pkg::SETUP_BIT])
    else $error("setup flag low during hold");
  a_setup_write_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE15
    (wr_a && !hold_d[0]) |=> !ep0_q[0][uaez_pkg::SETUP_BIT])
    else $error("cpu write did not clear setup flag");
  a_lock_blocks_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE19
    (wr_a && lock_q[0] && !tgt_now[0] && !(i_ack_start && cur_tgt_q[0]))
    |=> ep0_q[0][6:0] == $past(ep0_q[0][6:0]))
    else $error("locked endpoint-zero bits changed by cpu");
  a_read_unlocks: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE19
    (rd_a && !tgt_now[0] && !i_ack_start) |=> !lock_q[0])
    else $error("read did not unlock");
  a_setup_forces_nak: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE25
    (tgt_now[0] && i_tok_pid == uaez_pkg::UAEZ_PID_SETUP &&
     ep0_q[0][3:0] != uaez_pkg::MODE_DISABLE)
    |=> ep0_q[0][3:0] == uaez_pkg::MODE_NAK_INOUT)
    else $error("setup did not force nak mode");
  a_activity_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE26
    i_bus_event |=> sc_q[uaez_pkg::ACT_BIT])
    else $error("bus activity not set");
  a_fifo_protect: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE22
    (ep0_q[0][uaez_pkg::SETUP_BIT] && uaez_pkg::in_fifo(cfg[1], 3'h0, i_cpu_ram_addr))
    |-> !o_cpu_ram_we)
    else $error("cpu wrote endpoint-zero fifo during setup");
  a_ack_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE13
    (i_ack_start && cur_tgt_q[1]) |=> ep0_q[1][uaez_pkg::ACK_BIT])
    else $error("ack flag not set");
  a_disabled_stays: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE24
    (tgt_now[0] && ep0_q[0][3:0] == uaez_pkg::MODE_DISABLE && !wr_a)
    |=> ep0_q[0][3:0] == uaez_pkg::MODE_DISABLE)
    else $error("disabled endpoint zero changed mode");
  a_in_flag_set: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE14
    (tgt_now[0] && i_tok_pid == uaez_pkg::UAEZ_PID_IN &&
     ep0_q[0][3:0] != uaez_pkg::MODE_DISABLE) |=> ep0_q[0][uaez_pkg::IN_BIT])
    else $error("in received flag not set");
endmodule

// File: hw/uaez_pkg.sv
// Shared constants, types and layout functions for the address and endpoint-zero block
package uaez_pkg;
  // Register offsets on the CPU I/O port
  localparam logic [7:0] ADDR_A_OFS = 8'h10;
  localparam logic [7:0] EP0_A_OFS = 8'h12;
  localparam logic [7:0] ADDR_B_OFS = 8'h40;
  localparam logic [7:0] EP0_B_OFS = 8'h42;
  localparam logic [7:0] USB_SC_OFS = 8'h1F;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int ADDR_EN_BIT = 7;
  localparam int SETUP_BIT = 7;
  localparam int IN_BIT = 6;
  localparam int OUT_BIT = 5;
  localparam int ACK_BIT = 4;
  localparam int CFG_SIZE_BIT = 7;
  localparam int CFG_MODE_BIT = 6;
  localparam int DP_BIT = 5;
  localparam int DM_BIT = 4;
  localparam int ACT_BIT = 3;
  localparam logic [7:0] NONCTL_WMASK = 8'h9F;
  // Mode codes handled here
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  // Engine stall per byte written to a FIFO
  localparam logic [1:0] BYTE_STALL_CYC = 2'h3;
  localparam logic [5:0] FIFO_SMALL = 6'h08;
  localparam logic [5:0] FIFO_BIG = 6'h20;
  // Endpoint slots: A0..A4, B0 shares slot 3, B1 shares slot 4
  localparam logic [2:0] SLOT_B_OFS = 3'h3;
  localparam logic [2:0] SLOT_A_EPS_TWO = 3'h3;
  localparam logic [2:0] SLOT_B_EPS_TWO = 3'h2;
  localparam logic [2:0] SLOT_A_EPS_ONE = 3'h5;

  typedef enum logic [1:0] {
    UAEZ_PID_OUT = 2'b00,
    UAEZ_PID_IN = 2'b01,
    UAEZ_PID_SETUP = 2'b10,
    UAEZ_PID_NONE = 2'b11
  } uaez_pid_t;

  // FIFO start address of a slot for the chosen size bit
  function automatic logic [7:0] slot_base(input logic big_cfg, input logic [2:0] slot);
    logic [7:0] b;
    b = 8'h00;
    case (slot)
      3'h0: b = big_cfg ? 8'hB8 : 8'hF8;
      3'h1: b = big_cfg ? 8'hC0 : 8'hF0;
      3'h2: b = big_cfg ? 8'hE0 : 8'hE8;
      3'h3: b = big_cfg ? 8'hA8 : 8'hE0;
      3'h4: b = big_cfg ? 8'hB0 : 8'hD8;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // FIFO length of a slot
  function automatic logic [5:0] slot_size(input logic big_cfg, input logic [2:0] slot);
    return (big_cfg && (slot == 3'h1 || slot == 3'h2)) ? FIFO_BIG : FIFO_SMALL;
  endfunction

  // True when a RAM address falls in a slot's FIFO
  function automatic logic in_fifo(input logic big_cfg, input logic [2:0] slot,
                                   input logic [7:0] addr);
    logic [8:0] top;
    top = {1'b0, slot_base(big_cfg, slot)} + {3'h0, slot_size(big_cfg, slot)};
    return ({1'b0, addr} >= {1'b0, slot_base(big_cfg, slot)}) && ({1'b0, addr} < top);
  endfunction
endpackage

// File: hw/uaez_fifo_if.sv
// Carrier between the controller and its FIFO byte writer
`timescale 1ns/1ps
interface uaez_fifo_if;
  logic wr_req;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic busy;
  modport src (output wr_req, output wr_addr, output wr_data, input busy);
  modport sink (input wr_req, input wr_addr, input wr_data, output busy);
endinterface

// File: hw/uaez_ep_map.sv
// Token address match and endpoint slot routing
`timescale 1ns/1ps
module uaez_ep_map (
  input wire logic [1:0] i_cfg,
  input wire logic [7:0] i_addr_a,
  input wire logic [7:0] i_addr_b,
  input wire logic [6:0] i_tok_addr,
  input wire logic [3:0] i_tok_ep,
  output logic o_hit,
  output logic o_sel_b,
  output logic [2:0] o_slot
);
  logic hit_a;
  logic hit_b;
  logic one_addr;

  // Compare against enabled addresses only
  assign one_addr = i_cfg[0];
  assign hit_a = i_addr_a[uaez_pkg::ADDR_EN_BIT] && (i_addr_a[6:0] == i_tok_addr) && // RULE5
                 (i_tok_ep < {1'b0, one_addr ? uaez_pkg::SLOT_A_EPS_ONE
                                             : uaez_pkg::SLOT_A_EPS_TWO}); // RULE27
  // Cleared config gives A three endpoints and B two
  assign hit_b = !one_addr && i_addr_b[uaez_pkg::ADDR_EN_BIT] && // RULE2
                 (i_addr_b[6:0] == i_tok_addr) &&
                 (i_tok_ep < {1'b0, uaez_pkg::SLOT_B_EPS_TWO}); // RULE27
  assign o_hit = hit_a || hit_b;
  assign o_sel_b = hit_b && !hit_a;
  assign o_slot = o_sel_b ? (i_tok_ep[2:0] + uaez_pkg::SLOT_B_OFS) : i_tok_ep[2:0];
endmodule

// File: hw/uaez_fifo_wr.sv
// Engine-side FIFO byte writer that owns the data bus for three cycles per byte
`timescale 1ns/1ps
module uaez_fifo_wr (
  input wire logic i_clk,
  input wire logic i_rst_n,
  uaez_fifo_if.sink fifo,
  output logic o_cpu_stall,
  output logic o_ram_we,
  output logic [7:0] o_ram_addr,
  output logic [7:0] o_ram_wdata
);
  typedef enum logic [0:0] {
    UAEZ_WR_IDLE = 1'b0,
    UAEZ_WR_BUSY = 1'b1
  } uaez_wr_t;

  uaez_wr_t state_q;
  logic [1:0] cnt_q;

  // Bus ownership sequence
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= UAEZ_WR_IDLE;
      cnt_q <= 2'h0;
    end else begin
      case (state_q)
        UAEZ_WR_IDLE: begin
          if (fifo.wr_req) begin
            state_q <= UAEZ_WR_BUSY;
            cnt_q <= uaez_pkg::BYTE_STALL_CYC - 2'h1; // RULE9
          end
        end
        UAEZ_WR_BUSY: begin
          if (cnt_q == 2'h1) begin
            state_q <= UAEZ_WR_IDLE;
          end
          cnt_q <= cnt_q - 2'h1;
        end
        default: state_q <= UAEZ_WR_IDLE;
      endcase
    end
  end

  // Latched byte and address, write strobe at the end of the slot
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ram_addr <= 8'h00;
      o_ram_wdata <= 8'h00;
      o_ram_we <= 1'b0;
    end else begin
      if (fifo.wr_req && state_q == UAEZ_WR_IDLE) begin
        o_ram_addr <= fifo.wr_addr;
        o_ram_wdata <= fifo.wr_data;
      end
      o_ram_we <= (state_q == UAEZ_WR_BUSY) && (cnt_q == 2'h1);
    end
  end

  assign fifo.busy = (state_q == UAEZ_WR_BUSY);
  assign o_cpu_stall = fifo.wr_req || (state_q == UAEZ_WR_BUSY); // RULE9

  a_stall_three_cyc: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    (fifo.wr_req && state_q == UAEZ_WR_IDLE) |-> o_cpu_stall ##1 o_cpu_stall[*2] ##1 !fifo.busy)
    else $error("engine stall not three cycles per byte");
endmodule

// File: dv/uaez_host_model.sv
// Host-side link model issuing tokens, data bytes and handshakes
`timescale 1ns/1ps
module uaez_host_model (
  input wire logic i_clk,
  output logic o_tok_valid,
  output logic [1:0] o_tok_pid,
  output logic [6:0] o_tok_addr,
  output logic [3:0] o_tok_ep,
  output logic o_data_start,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_ack_start,
  output logic o_txn_end,
  output logic o_bus_event
);
  // Idle link at time zero
  initial begin
    {o_tok_valid, o_data_start, o_rx_valid, o_ack_start, o_txn_end, o_bus_event} = 6'h00;
    o_tok_pid = uaez_pkg::UAEZ_PID_NONE;
    {o_tok_addr, o_tok_ep, o_rx_byte} = 19'h00000;
  end
  // Token fields without a strobe
  task automatic aim(input logic [6:0] a, input logic [3:0] e);
    @(posedge i_clk);
    o_tok_addr <= a;
    o_tok_ep <= e;
  endtask
  // Token phase, seen as bus activity too
  task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e);
    @(posedge i_clk);
    {o_tok_valid, o_bus_event} <= 2'h3;
    o_tok_pid <= p;
    o_tok_addr <= a;
    o_tok_ep <= e;
    @(posedge i_clk);
    {o_tok_valid, o_bus_event} <= 2'h0;
  endtask
  // Data packet, bytes spaced by gap idle cycles
  task automatic data(input int n, input logic [7:0] b, input int gap);
    @(posedge i_clk);
    o_data_start <= 1'b1;
    @(posedge i_clk);
    o_data_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_rx_valid <= 1'b1;
      o_rx_byte <= b + 8'(i);
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_byte <= ~(b + 8'(i)); // Released lane shows the inverse
      repeat (gap) @(posedge i_clk);
    end
  endtask
  // Handshake then end of transaction
  task automatic ack();
    @(posedge i_clk);
    o_ack_start <= 1'b1;
    @(posedge i_clk);
    {o_ack_start, o_txn_end} <= 2'h1;
    @(posedge i_clk);
    o_txn_end <= 1'b0;
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the address and endpoint-zero block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] x;} uaez_row_t;
  typedef struct packed {logic [7:0] c; logic [6:0] a; logic [3:0] e; logic [4:0] x;} uaez_prb_t;
  logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ram_we = 1'b0;
  logic [7:0] io_a = 8'h00, io_d = 8'h00, ram_a = 8'h00, rdat, ra, rwd, rb;
  logic [6:0] ta;
  logic [3:0] te, em, em_s;
  logic [2:0] sl, fc;
  logic [1:0] tp;
  logic gwe, tv, ds, rv, as, tx, be, hit, sb, ign, st, rw, ign_s;
  int fails = 0, comparisons = 0, cyc = 0, nst = 0;
  logic [15:0] wq[$];
  logic [7:0] base[2] = '{8'hF8, 8'hB8};
  logic [7:0] regs[4] = '{8'h10, 8'h12, 8'h40, 8'h42};
  // Register offset, write value, value read back
  uaez_row_t rows[11] = '{'{8'h10, 8'h85, 8'h85}, '{8'h40, 8'h86, 8'h86},
    '{8'h33, 8'hFF, 8'h00}, '{8'h12, 8'hFF, 8'h7F}, '{8'h42, 8'hE1, 8'h61},
    '{8'h1F, 8'hC7, 8'hE7}, '{8'h1F, 8'h40, 8'h60}, '{8'h42, 8'hFF, 8'h9F},
    '{8'h1F, 8'h00, 8'h20}, '{8'h42, 8'h61, 8'h61}, '{8'h12, 8'h02, 8'h02}};
  // Config, token address and endpoint, expected hit, B select and slot
  uaez_prb_t prb[9] = '{'{8'h00, 7'h05, 4'h0, 5'h10}, '{8'h00, 7'h05, 4'h2, 5'h12},
    '{8'h00, 7'h05, 4'h3, 5'h00}, '{8'h00, 7'h06, 4'h0, 5'h1B}, '{8'h00, 7'h06, 4'h1, 5'h1C},
    '{8'h00, 7'h06, 4'h2, 5'h00}, '{8'h00, 7'h07, 4'h0, 5'h00}, '{8'h40, 7'h05, 4'h4, 5'h14},
    '{8'hC0, 7'h05, 4'h3, 5'h13}};
  always #20 clk = ~clk;
  uaez_host_model i_uaez_host_model (.i_clk(clk), .o_tok_valid(tv), .o_tok_pid(tp),
    .o_tok_addr(ta), .o_tok_ep(te), .o_data_start(ds), .o_rx_valid(rv), .o_rx_byte(rb),
    .o_ack_start(as), .o_txn_end(tx), .o_bus_event(be));
  uaez_ctrl i_uaez_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_io_addr(io_a), .i_io_wr(wr_s),
    .i_io_rd(rd_s), .i_io_wdata(io_d), .o_io_rdata(rdat), .i_cpu_ram_we(ram_we),
    .i_cpu_ram_addr(ram_a), .o_cpu_ram_we(gwe), .i_tok_valid(tv), .i_tok_pid(tp),
    .i_tok_addr(ta), .i_tok_ep(te), .i_data_start(ds), .i_rx_valid(rv), .i_rx_byte(rb),
    .i_ack_start(as), .i_txn_end(tx), .i_bus_event(be), .i_dp(1'b1), .i_dm(1'b0),
    .o_tok_hit(hit), .o_tok_sel_b(sb), .o_tok_slot(sl), .o_ep0_ignore(ign), .o_ep0_mode(em),
    .o_force_ctl(fc), .o_cpu_stall(st), .o_ram_we(rw), .o_ram_addr(ra), .o_ram_wdata(rwd));
  // Stall count, engine FIFO writes, token-cycle answers and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (st === 1'b1) nst <= nst + 1;
    if (rw === 1'b1) wq.push_back({ra, rwd});
    if (tv === 1'b1) {ign_s, em_s} <= {ign, em};
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_a <= a;
    io_d <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    io_a <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdat}, {8'h00, x});
  endtask
  task automatic complete_run();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].x);
    end
    $display("test registers done");
    foreach (prb[i]) begin
      wr(8'h1F, prb[i].c);
      i_uaez_host_model.aim(prb[i].a, prb[i].e);
      @(negedge clk);
      chk({11'h000, hit ? {1'b1, sb, sl} : 5'h00}, {11'h000, prb[i].x});
    end
    wr(8'h1F, 8'h00);
    wr(8'h40, 8'h06);
    i_uaez_host_model.aim(7'h06, 4'h0);
    @(negedge clk);
    chk({15'h0000, hit}, 16'h0000);
    wr(8'h40, 8'h86);
    $display("test routing done");
    wr(8'h12, 8'h00);
    i_uaez_host_model.token(uaez_pkg::UAEZ_PID_SETUP, 7'h05, 4'h0);
    rd(8'h12, 8'h00);
    chk({11'h000, ign_s, em_s}, 16'h0010);
    for (int k = 0; k < 2; k++) begin
      wr(8'h1F, k ? 8'h80 : 8'h00);
      wr(8'h12, 8'h02);
      i_uaez_host_model.token(uaez_pkg::UAEZ_PID_SETUP, 7'h05, 4'h0);
      nst = 0;
      i_uaez_host_model.data(2, 8'hA0 + 8'(k), 3 + 3 * k);
      chk({11'h000, ign_s, em_s}, 16'h0002);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h81);
      @(posedge clk);
      ram_we <= 1'b1;
      ram_a <= base[k];
      @(negedge clk);
      chk({15'h0000, gwe}, 16'h0000);
      @(posedge clk);
      ram_a <= base[k] ^ 8'h10;
      @(negedge clk);
      chk({15'h0000, gwe}, 16'h0001);
      @(posedge clk);
      ram_we <= 1'b0;
      i_uaez_host_model.ack();
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h11);
      chk(16'(nst), 16'h0006);
      chk(wq[0], {base[k], 8'hA0 + 8'(k)});
      chk(wq[1], {base[k] + 8'h01, 8'hA1 + 8'(k)});
      wq.delete();
    end
    $display("test setup done");
    wr(8'h1F, 8'h00);
    for (int j = 0; j < 3; j++) begin
      wr(j == 2 ? 8'h42 : 8'h12, 8'h02);
      i_uaez_host_model.token(j == 1 ? 2'b01 : 2'b00, j == 2 ? 7'h06 : 7'h05, 4'h0);
      i_uaez_host_model.ack();
      rd(j == 2 ? 8'h42 : 8'h12, j == 1 ? 8'h52 : 8'h32);
    end
    rd(8'h1F, 8'h28);
    wr(8'h1F, 8'h0D);
    rd(8'h1F, 8'h2D);
    chk({13'h0000, fc}, 16'h0005);
    wr(8'h1F, 8'h00);
    rd(8'h1F, 8'h20);
    $display("test flags done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    $display("test reset done");
    complete_run();
  end
endmodule
